// File: design/se_pkg.sv
// Shared constants, encodings and state types for both ends of the serial EEPROM link.
package se_pkg;
  localparam logic [1:0]  OPC_READ     = 2'h2;
  localparam logic [1:0]  OPC_WRITE    = 2'h1;
  localparam logic [1:0]  OPC_ERASE    = 2'h3;
  localparam logic [1:0]  OPC_EXT      = 2'h0;
  localparam logic [1:0]  EXT_UNLOCK   = 2'h3;
  localparam logic [1:0]  EXT_ERASE_ALL_CMD     = 2'h2;
  localparam logic [1:0]  EXT_FILL     = 2'h1;
  localparam logic [1:0]  EXT_LOCK     = 2'h0;
  localparam logic [4:0]  FLD_X16      = 5'h0a;
  localparam logic [4:0]  FLD_X8       = 5'h0b;
  localparam logic [4:0]  DAT_X16      = 5'h10;
  localparam logic [4:0]  DAT_X8       = 5'h08;
  localparam logic [10:0] MASK_BIG_X16 = 11'h3ff;
  localparam logic [10:0] MASK_BIG_X8  = 11'h7ff;
  localparam logic [10:0] MASK_SML_X16 = 11'h1ff;
  localparam logic [10:0] MASK_SML_X8  = 11'h3ff;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam int          CLK_MHZ      = 200;
  localparam int          CLK_NS       = 5;
  localparam int          TCKH_NS      = 300;
  localparam int          TCKL_NS      = 200;
  localparam int          TCSL_NS      = 250;
  localparam int          TWC_MS       = 10;
  localparam int          TEC_MS       = 15;
  localparam int          TWL_MS       = 30;
  localparam logic [7:0]  CKH_CYC      = 8'((TCKH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  CKL_CYC      = 8'((TCKL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  CSL_CYC      = 8'((TCSL_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned WC_CYC       = TWC_MS * 1000 * CLK_MHZ;
  localparam int unsigned EC_CYC       = TEC_MS * 1000 * CLK_MHZ;
  localparam int unsigned WL_CYC       = TWL_MS * 1000 * CLK_MHZ;
  typedef enum logic [2:0] {
    CMD_NONE   = 3'h0,
    CMD_READ   = 3'h1,
    CMD_WRITE  = 3'h2,
    CMD_ERASE  = 3'h3,
    CMD_ERASE_ALL_CMD   = 3'h4,
    CMD_FILL   = 3'h5,
    CMD_UNLOCK = 3'h6,
    CMD_LOCK   = 3'h7
  } se_cmd_e;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SHIFT  = 2'h1,
    ST_READ   = 2'h2,
    ST_STATUS = 2'h3
  } se_dev_st_e;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_LO   = 3'h1,
    H_HI   = 3'h2,
    H_PUSH = 3'h3,
    H_POLL = 3'h4,
    H_GAP  = 3'h5
  } se_host_st_e;
endpackage

// File: design/se_link_if.sv
// Four-wire link between host and device, with the pulled-up serial output line.
interface se_link_if;
  logic select;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  logic so_line;
  assign so_line = serial_out_oe_n ? 1'b1 : serial_out;
  modport host (output select, output sclk, output serial_in, input so_line);
  modport device (input select, input sclk, input serial_in, output serial_out, output serial_out_oe_n);
endinterface

// File: design/se_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
module se_fifo import se_pkg::*; #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;
  assign in_ready_o  = cnt != (AW+1)'(DEPTH);
  assign out_valid_o = cnt != '0;
  assign out_data_o  = mem[rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: design/se_device.sv
// Device end: serial command decoder, write-enable latch, word store and busy timer.
// Rules this block follows, plus R17 for the master
// R1: Start is first rise with select, input high.
// R2: Before start, other pin activity does nothing.
// R3: Execute only after every needed bit arrives.
// R4: After last bit, ignore pins until start.
// R5: Bits sampled on rising link clock edge.
// R6: Output released except read data or status.
// R7: Status low while programming, high when ready.
// R8: Output released when select falls.
// R9: Width select high gives 16-bit, low 8-bit.
// R10: Larger part x16: 10 address bits, 29/13.
// R11: Larger part x8: 11 address bits, 22/14.
// R12: Smaller part x8: don't-care, ten address bits.
// R13: Extended opcode decoded from two field bits.
// R14: Write-enable latch starts locked at power-up.
// R15: Unlock holds until lock; locked refuses programming.
// R16: Reads ignore the write-enable latch.
// R17: Master should lock after programming.
// R18: Leave standby as soon as select rises.
// R19: Smaller part x16: don't-care, nine address bits.
// R20: Read: dummy zero, data, then auto-increment stream.
// R21: Programming starts at last bit; status shown.
// R22: Select low resets commands; programming still completes.
// R23: Busy lengths from parameterised counter per kind.
module se_device import se_pkg::*; #(
  parameter int          WORDS    = 32,
  parameter bit          BIG_PART = 1'b1,
  parameter int unsigned T_WORD   = WC_CYC,
  parameter int unsigned T_ERASE_ALL_CMD   = EC_CYC,
  parameter int unsigned T_FILL_ALL_CMD   = WL_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  se_link_if.device link,
  input  wire logic width_select_i,
  input  wire logic write_protect_n_pin_i,
  output logic      busy_o,
  output logic      unlocked_o,
  output logic      standby_o
);
  localparam int IW = $clog2(WORDS);

  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic        sclk_d;
  logic        sel;
  logic        sin;
  logic        wide;
  logic        wp_n;
  logic        rise;
  se_dev_st_e  st;
  logic [4:0]  cnt;
  logic [1:0]  op_q;
  logic [10:0] field;
  logic [10:0] nfield;
  logic [15:0] data_q;
  logic [15:0] ndata;
  se_cmd_e     cmd_q;
  se_cmd_e     fcmd;
  se_cmd_e     xcmd;
  logic [10:0] addr_q;
  logic [10:0] xaddr;
  logic [10:0] amask;
  logic [4:0]  fld_n;
  logic [4:0]  dat_n;
  logic [1:0]  ext;
  logic        last_fld;
  logic        last_dat;
  logic        exec;
  logic        prog;
  logic        is_all;
  logic        unlocked;
  logic [31:0] tmr;
  logic        busy;
  logic [15:0] mem [WORDS];
  logic [15:0] wword;
  logic        out_q;
  logic [15:0] rd_sh;
  logic [4:0]  bcnt;
  logic [10:0] raddr;
  logic [10:0] inc_addr;
  logic [15:0] nxt_word;

  // The link pins come from another clock domain, so each passes two flops first.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {link.select, link.sclk, link.serial_in, width_select_i, write_protect_n_pin_i};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sync2[3];
    end
  end

  assign sel  = sync2[4];
  assign sin  = sync2[2];
  assign wide = sync2[1];
  assign wp_n = sync2[0];
  assign rise = sync2[3] && !sclk_d; // R5

  assign fld_n = wide ? FLD_X16 : FLD_X8; // R9
  assign dat_n = wide ? DAT_X16 : DAT_X8; // R9

  always_comb begin
    case ({BIG_PART, wide})
      2'h3:    amask = MASK_BIG_X16; // R10
      2'h2:    amask = MASK_BIG_X8; // R11
      2'h1:    amask = MASK_SML_X16; // R19
      default: amask = MASK_SML_X8; // R12
    endcase
  end

  assign nfield   = {field[9:0], sin};
  assign ndata    = {data_q[14:0], sin};
  assign ext      = wide ? nfield[9:8] : nfield[10:9]; // R13
  assign last_fld = rise && st == ST_SHIFT && cnt == fld_n + 5'h01; // R3
  assign last_dat = rise && st == ST_SHIFT && (cmd_q == CMD_WRITE || cmd_q == CMD_FILL)
                    && cnt == fld_n + dat_n + 5'h01; // R3

  always_comb begin
    case (op_q)
      OPC_READ:  fcmd = CMD_READ;
      OPC_WRITE: fcmd = CMD_WRITE;
      OPC_ERASE: fcmd = CMD_ERASE;
      default: begin
        case (ext)
          EXT_UNLOCK: fcmd = CMD_UNLOCK; // R13
          EXT_ERASE_ALL_CMD:   fcmd = CMD_ERASE_ALL_CMD; // R13
          EXT_FILL:   fcmd = CMD_FILL; // R13
          default:    fcmd = CMD_LOCK; // R13
        endcase
      end
    endcase
  end

  assign exec   = last_dat || (last_fld && fcmd != CMD_WRITE && fcmd != CMD_FILL && fcmd != CMD_READ);
  assign xcmd   = last_dat ? cmd_q : fcmd;
  assign xaddr  = last_dat ? addr_q : (nfield & amask);
  assign is_all = xcmd == CMD_ERASE_ALL_CMD || xcmd == CMD_FILL;
  // A refused programming command falls through to idle with the output released.
  assign prog   = exec && unlocked && wp_n && !busy
                  && (xcmd == CMD_ERASE || xcmd == CMD_WRITE || is_all); // R15
  assign wword  = wide ? ndata : {8'h00, ndata[7:0]};

  // Select low holds the command logic in reset; the busy timer is not touched.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !sel) begin // R22
      st  <= ST_IDLE;
      cnt <= '0;
    end else if (rise) begin
      case (st)
        ST_IDLE, ST_STATUS: begin
          if (sin) begin // R1 R2 R4 R21
            st  <= ST_SHIFT;
            cnt <= '0;
          end
        end
        ST_SHIFT: begin
          cnt <= cnt + 5'h01;
          if (last_fld && fcmd == CMD_READ) begin
            st <= ST_READ; // R16
          end else if (exec) begin
            st <= prog ? ST_STATUS : ST_IDLE; // R4 R21
          end
        end
        ST_READ: st <= ST_READ; // R20
        default: st <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      op_q   <= '0;
      field  <= '0;
      data_q <= '0;
      cmd_q  <= CMD_NONE;
      addr_q <= '0;
    end else if (rise && (st == ST_IDLE || st == ST_STATUS)) begin
      data_q <= '0;
      cmd_q  <= CMD_NONE;
    end else if (rise && st == ST_SHIFT) begin
      if (cnt < 5'h02) begin
        op_q <= {op_q[0], sin}; // R5
      end else if (cnt < fld_n + 5'h02) begin
        field <= nfield;
      end else begin
        data_q <= ndata;
      end
      if (last_fld) begin
        cmd_q  <= fcmd;
        addr_q <= nfield & amask;
      end
    end
  end

  for (genvar i = 0; i < WORDS; i++) begin : g_mem
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        mem[i] <= ERASED_WORD;
      end else if (prog && (is_all || xaddr[IW-1:0] == IW'(i))) begin
        mem[i] <= (xcmd == CMD_WRITE || xcmd == CMD_FILL) ? wword : ERASED_WORD; // R21
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      unlocked <= 1'b0; // R14
    end else if (exec && xcmd == CMD_UNLOCK) begin
      unlocked <= 1'b1; // R15
    end else if (exec && xcmd == CMD_LOCK) begin
      unlocked <= 1'b0; // R15
    end
  end

  // The timer keeps running with select low so a started cycle always finishes.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tmr <= '0;
    end else if (prog) begin
      tmr <= xcmd == CMD_ERASE_ALL_CMD ? T_ERASE_ALL_CMD : xcmd == CMD_FILL ? T_FILL_ALL_CMD : T_WORD; // R23
    end else if (tmr != '0) begin
      tmr <= tmr - 32'h1; // R22
    end
  end
  assign busy = tmr != '0;

  // In x8 the byte sits in the low half and is moved to the top before shifting.
  function automatic logic [15:0] align(input logic [15:0] w, input logic wd);
    align = wd ? w : {w[7:0], 8'h00};
  endfunction

  assign inc_addr = (raddr + 11'h001) & amask;
  assign nxt_word = align(mem[IW'(inc_addr)], wide);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
      rd_sh <= '0;
      bcnt  <= '0;
      raddr <= '0;
    end else if (last_fld && fcmd == CMD_READ) begin
      raddr <= nfield & amask;
      rd_sh <= align(mem[IW'(nfield & amask)], wide);
      out_q <= 1'b0; // R20
      bcnt  <= '0;
    end else if (prog) begin
      out_q <= 1'b0; // R7
    end else if (st == ST_STATUS) begin
      out_q <= !busy; // R7
    end else if (rise && st == ST_READ) begin
      if (bcnt == dat_n) begin
        raddr <= inc_addr; // R20
        out_q <= nxt_word[15];
        rd_sh <= {nxt_word[14:0], 1'b0};
        bcnt  <= 5'h01;
      end else begin
        out_q <= rd_sh[15]; // R20
        rd_sh <= {rd_sh[14:0], 1'b0};
        bcnt  <= bcnt + 5'h01;
      end
    end
  end

  assign link.serial_out      = out_q;
  assign link.serial_out_oe_n = !(sel && (st == ST_READ || st == ST_STATUS)); // R6 R8
  assign busy_o               = busy;
  assign unlocked_o           = unlocked;
  assign standby_o            = !sel && !busy; // R18
endmodule

// File: design/se_host.sv
// Host end: builds command frames, clocks the link, polls status and buffers read words.
module se_host import se_pkg::*; (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  se_link_if.host          link,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire se_cmd_e     cmd_op_i,
  input  wire logic [10:0] cmd_addr_i,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic [7:0]  cmd_words_i,
  input  wire logic        width_select_i,
  output logic             rd_valid_o,
  input  wire logic        rd_ready_i,
  output logic [15:0]      rd_data_o,
  output logic             done_o
);
  se_host_st_e st;
  logic [1:0]  so_sync;
  logic [28:0] frame;
  logic [28:0] nframe;
  logic [4:0]  nleft;
  logic [4:0]  nbits;
  logic [1:0]  opc;
  logic [1:0]  xc;
  logic [10:0] fld;
  logic [7:0]  tmr;
  logic [15:0] rx_sh;
  logic [4:0]  rx_n;
  logic [7:0]  words;
  se_cmd_e     op_q;
  logic        wide_q;
  logic        sel_q;
  logic        sclk_q;
  logic        sin_q;
  logic        done_q;
  logic        f_ready;
  logic        is_prog;

  always_comb begin
    opc = OPC_EXT;
    xc  = EXT_LOCK;
    case (cmd_op_i)
      CMD_READ:   opc = OPC_READ;
      CMD_WRITE:  opc = OPC_WRITE;
      CMD_ERASE:  opc = OPC_ERASE;
      CMD_ERASE_ALL_CMD:   xc  = EXT_ERASE_ALL_CMD;
      CMD_FILL:   xc  = EXT_FILL;
      CMD_UNLOCK: xc  = EXT_UNLOCK;
      default:    xc  = EXT_LOCK;
    endcase
    if (opc != OPC_EXT) begin
      fld = cmd_addr_i;
    end else begin
      fld = width_select_i ? {1'b0, xc, 8'h00} : {xc, 9'h000};
    end
    if (width_select_i) begin
      nframe = {1'b1, opc, fld[9:0], cmd_data_i};
    end else begin
      nframe = {1'b1, opc, fld, cmd_data_i[7:0], 7'h00};
    end
    nbits = 5'h03 + (width_select_i ? FLD_X16 : FLD_X8);
    if (cmd_op_i == CMD_WRITE || cmd_op_i == CMD_FILL) begin
      nbits = nbits + (width_select_i ? DAT_X16 : DAT_X8);
    end
  end

  assign is_prog = op_q == CMD_WRITE || op_q == CMD_ERASE || op_q == CMD_ERASE_ALL_CMD || op_q == CMD_FILL;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      so_sync <= 2'h3;
    end else begin
      so_sync <= {so_sync[0], link.so_line};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st     <= H_IDLE;
      frame  <= '0;
      nleft  <= '0;
      tmr    <= '0;
      rx_sh  <= '0;
      rx_n   <= '0;
      words  <= '0;
      op_q   <= CMD_NONE;
      wide_q <= 1'b1;
      sel_q  <= 1'b0;
      sclk_q <= 1'b0;
      sin_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st)
        H_IDLE: begin
          if (cmd_valid_i) begin
            frame  <= nframe << 1;
            sin_q  <= 1'b1;
            nleft  <= nbits;
            op_q   <= cmd_op_i;
            wide_q <= width_select_i;
            words  <= (cmd_words_i == 8'h00) ? 8'h01 : cmd_words_i;
            rx_n   <= '0;
            sel_q  <= 1'b1;
            tmr    <= CKL_CYC;
            st     <= H_LO;
          end
        end
        H_LO: begin
          tmr <= tmr - 8'h01;
          if (tmr == 8'h00) begin
            sclk_q <= 1'b1;
            tmr    <= CKH_CYC;
            st     <= H_HI;
          end
        end
        H_HI: begin
          tmr <= tmr - 8'h01;
          if (tmr == 8'h00) begin
            sclk_q <= 1'b0;
            sin_q  <= frame[28];
            frame  <= frame << 1;
            tmr    <= CKL_CYC;
            if (nleft != 5'h00) begin
              nleft <= nleft - 5'h01;
              if (nleft != 5'h01) begin
                st <= H_LO;
              end else if (op_q == CMD_READ) begin
                st <= H_LO;
              end else if (is_prog) begin
                st <= H_POLL;
              end else begin
                sel_q <= 1'b0;
                tmr   <= CSL_CYC;
                st    <= H_GAP;
              end
            end else begin
              rx_sh <= {rx_sh[14:0], so_sync[1]};
              rx_n  <= rx_n + 5'h01;
              st    <= (rx_n == (wide_q ? DAT_X16 : DAT_X8) - 5'h01) ? H_PUSH : H_LO;
            end
          end
        end
        H_PUSH: begin
          if (f_ready) begin
            rx_n  <= '0;
            words <= words - 8'h01;
            if (words == 8'h01) begin
              sel_q <= 1'b0;
              tmr   <= CSL_CYC;
              st    <= H_GAP;
            end else begin
              st <= H_LO;
            end
          end
        end
        H_POLL: begin
          if (so_sync[1]) begin
            sel_q <= 1'b0;
            tmr   <= CSL_CYC;
            st    <= H_GAP;
          end
        end
        H_GAP: begin
          tmr <= tmr - 8'h01;
          if (tmr == 8'h00) begin
            done_q <= 1'b1;
            st     <= H_IDLE;
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  // A full FIFO parks the link clock low, so back-pressure reaches the device.
  se_fifo #(.W(16), .DEPTH(4)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (st == H_PUSH),
    .in_ready_o  (f_ready),
    .in_data_i   (wide_q ? rx_sh : {8'h00, rx_sh[7:0]}),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (rd_data_o)
  );

  assign link.select    = sel_q;
  assign link.sclk      = sclk_q;
  assign link.serial_in = sin_q;
  assign cmd_ready_o    = st == H_IDLE;
  assign done_o         = done_q;
endmodule

// File: tb/se_link_monitor.sv
// Checker of release, status, busy and latch behaviour on the host-device link.
module se_link_monitor #(
  parameter int unsigned T_MIN = 200
) (
  input logic clk_sys_i,
  input logic rst_i,
  input logic select,
  input logic sclk,
  input logic serial_out,
  input logic serial_out_oe_n,
  input logic busy_o,
  input logic unlocked_o,
  input logic standby_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        sclk_q;
  logic [5:0]  rise_cnt;
  int unsigned busy_len;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_sys_i) sclk_q <= sclk;
  // Saturates so that a long sequential read cannot wrap back below the frame length.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !select) rise_cnt <= 6'h00;
    else if (sclk && !sclk_q && rise_cnt != 6'h3f) rise_cnt <= rise_cnt + 6'h01;
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !busy_o) busy_len <= 0;
    else busy_len <= busy_len + 1;
  end
  sequence s_busy_status;
    (busy_o && !serial_out_oe_n) [*2];
  endsequence
  sequence s_busy_ends;
    $fell(busy_o) ##1 !serial_out_oe_n;
  endsequence
  a_release_on_deselect: assert property ((!select) [*5] |-> serial_out_oe_n)
    else $error("Output driven after deselect.");
  a_drive_needs_select: assert property (!serial_out_oe_n |-> select || $past(select, 4))
    else $error("Output driven without select.");
  a_drive_after_frame: assert property ($fell(serial_out_oe_n) |-> rise_cnt >= 6'h0d)
    else $error("Output driven before frame end.");
  a_status_shows_busy: assert property (s_busy_status |-> !serial_out)
    else $error("Status not low while busy.");
  a_ready_after_busy: assert property (s_busy_ends |-> serial_out)
    else $error("Status not high when ready.");
  a_busy_in_frame: assert property ($rose(busy_o) |-> select && sclk)
    else $error("Programming began outside a clock high phase.");
  a_busy_needs_unlock: assert property ($rose(busy_o) |-> unlocked_o)
    else $error("Programming while locked.");
  a_busy_min_len: assert property ($fell(busy_o) |-> busy_len >= T_MIN)
    else $error("Busy period too short.");
  a_latch_in_frame: assert property ($changed(unlocked_o) |-> select && sclk)
    else $error("Latch changed outside a frame.");
  a_latch_locked_start: assert property ($fell(rst_i) |-> !unlocked_o)
    else $error("Latch not locked after reset.");
  a_wake_on_select: assert property (select [*5] |-> !standby_o)
    else $error("Still in standby while selected.");
endmodule

// File: tb/se_bench.sv
// Bench joining host and device ends, plus a second device fed by a deliberately faulty link driver.
module se_bench import se_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TW = 200;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        cmd_valid, cmd_ready, rd_valid, rd_ready, done, wsel, wp_n, drain, take, exp_unl;
  logic        busy, unlocked, standby, unlocked2, standby2;
  se_cmd_e     cmd_op;
  logic [10:0] cmd_addr, a;
  logic [15:0] cmd_data, rd_data, d;
  logic [7:0]  cmd_words;
  logic [15:0] exp_mem [32];
  logic [15:0] rd_q [$];
  int          failures    = 0;
  int          check_count = 0;
  int          seed        = 32;
  se_link_if link ();
  se_link_if link2 ();
  always #2.5 clk_sys_i = ~clk_sys_i;
  se_host se_host_i (.clk_sys_i, .rst_i, .link(link), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_words_i(cmd_words),
    .width_select_i(wsel), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data), .done_o(done));
  se_device #(.T_WORD(TW), .T_ERASE_ALL_CMD(300), .T_FILL_ALL_CMD(600)) se_device_i (.clk_sys_i, .rst_i, .link(link),
    .width_select_i(wsel), .write_protect_n_pin_i(wp_n), .busy_o(busy), .unlocked_o(unlocked), .standby_o(standby));
  se_device #(.T_WORD(TW), .T_ERASE_ALL_CMD(300), .T_FILL_ALL_CMD(600)) se_device_fault_i (.clk_sys_i, .rst_i, .link(link2),
    .width_select_i(wsel), .write_protect_n_pin_i(wp_n), .busy_o(), .unlocked_o(unlocked2), .standby_o(standby2));
  se_link_monitor #(.T_MIN(TW)) se_link_monitor_i (.clk_sys_i, .rst_i, .select(link.select), .sclk(link.sclk),
    .serial_out(link.serial_out), .serial_out_oe_n(link.serial_out_oe_n), .busy_o(busy), .unlocked_o(unlocked),
    .standby_o(standby));
  // The ready decision is made first so the recorded word is the one the coming edge takes.
  always @(negedge clk_sys_i) begin
    take = drain && (($random(seed) & 3) != 0);
    if (rd_valid === 1'b1 && take) rd_q.push_back(rd_data);
    rd_ready <= take;
  end
  function automatic logic [15:0] shape(input logic [15:0] v);
    return wsel ? v : {8'h00, v[7:0]};
  endfunction
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic guard(input int k);
    if (k >= 60000) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic issue(input se_cmd_e op, input logic [10:0] ad, input logic [15:0] dt, input logic [7:0] n);
    int k;
    for (k = 0; k < 60000 && cmd_ready !== 1'b1; k++) @(negedge clk_sys_i);
    guard(k);
    cmd_op = op;
    cmd_addr = ad;
    cmd_data = dt;
    cmd_words = n;
    cmd_valid = 1'b1;
    @(negedge clk_sys_i);
    cmd_valid = 1'b0;
  endtask
  task automatic finish(input se_cmd_e op, input logic [10:0] ad, input logic [15:0] dt, input logic [7:0] n);
    int k;
    int nn;
    logic [15:0] nv;
    nn = (n == 0) ? 1 : n;
    for (k = 0; k < 60000 && done !== 1'b1; k++) @(negedge clk_sys_i);
    guard(k);
    for (k = 0; k < 60000 && op == CMD_READ && rd_q.size() < nn; k++) @(negedge clk_sys_i);
    guard(k);
    if (op == CMD_READ)
      for (int i = 0; i < nn; i++) check_word(rd_q.pop_front(), shape(exp_mem[5'(ad + 11'(i))]));
    nv = (op inside {CMD_WRITE, CMD_FILL}) ? shape(dt) : ERASED_WORD;
    if (exp_unl && wp_n && op inside {CMD_WRITE, CMD_ERASE, CMD_ERASE_ALL_CMD, CMD_FILL})
      for (int i = 0; i < 32; i++)
        if (op inside {CMD_ERASE_ALL_CMD, CMD_FILL} || 5'(i) == ad[4:0]) exp_mem[i] = nv;
    if (op inside {CMD_UNLOCK, CMD_LOCK}) exp_unl = (op == CMD_UNLOCK);
    check_flag(unlocked, exp_unl);
  endtask
  task automatic run(input se_cmd_e op, input logic [10:0] ad, input logic [15:0] dt, input logic [7:0] n);
    issue(op, ad, dt, n);
    finish(op, ad, dt, n);
  endtask
  // Bit-bangs the second link with a 64 ns clock, free of the system clock's phase.
  task automatic bang(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link2.serial_in = v[i];
      #32 link2.sclk = 1'b1;
      #32 link2.sclk = 1'b0;
    end
  endtask
  initial begin
    {cmd_valid, link2.select, link2.sclk, link2.serial_in, exp_unl} = 5'h00;
    {cmd_addr, cmd_data, cmd_words} = '0;
    cmd_op = CMD_NONE;
    {wsel, wp_n, drain} = 3'h7;
    for (int i = 0; i < 32; i++) exp_mem[i] = ERASED_WORD;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    check_flag(unlocked, 1'b0);
    check_flag(standby, 1'b1);
    #3 link2.select = 1'b1;
    bang(16'h0980, 12);
    #64 link2.select = 1'b0;
    #300 check_flag(unlocked2, 1'b0);
    link2.select = 1'b1;
    #100 check_flag(standby2, 1'b0);
    bang(16'h1300, 16);
    #200 check_flag(unlocked2, 1'b1);
    link2.select = 1'b0;
    @(negedge clk_sys_i);
    a = 11'($random(seed));
    d = 16'($random(seed));
    run(CMD_WRITE, a, d, 8'h01);
    run(CMD_READ, a, d, 8'h01);
    run(CMD_UNLOCK, a, d, 8'h01);
    for (int i = 0; i < 3; i++) run(CMD_WRITE, a + 11'(i), 16'($random(seed)), 8'h01);
    run(CMD_READ, a, d, 8'h03);
    run(CMD_ERASE, a + 11'h001, d, 8'h01);
    run(CMD_READ, a + 11'h001, d, 8'h00);
    run(CMD_FILL, a, d, 8'h01);
    run(CMD_READ, 11'h3ff, d, 8'h02);
    run(CMD_ERASE_ALL_CMD, a, d, 8'h01);
    run(CMD_READ, a, d, 8'h01);
    run(CMD_LOCK, a, d, 8'h01);
    run(CMD_WRITE, a, ~d, 8'h01);
    run(CMD_READ, a, d, 8'h01);
    wsel = 1'b0;
    idle(4);
    run(CMD_UNLOCK, a, d, 8'h01);
    run(CMD_WRITE, 11'h7ff, d, 8'h01);
    run(CMD_READ, 11'h7ff, d, 8'h02);
    wp_n = 1'b0;
    idle(4);
    run(CMD_WRITE, 11'h7ff, ~d, 8'h01);
    run(CMD_READ, 11'h7ff, d, 8'h01);
    {wsel, wp_n, drain} = 3'h6;
    idle(4);
    issue(CMD_READ, a, d, 8'h06);
    // With the reader stalled the buffer fills and the host must hold the link.
    idle(12000);
    check_flag(cmd_ready, 1'b0);
    check_flag(rd_valid, 1'b1);
    drain = 1'b1;
    finish(CMD_READ, a, d, 8'h06);
    report_and_stop();
  end
endmodule
